// ==== src/input_mailbox_defs.vh ====
// Constants for the isolated input mailbox command interpreter.
// Assumes one 40 MHz clock and a host that writes one command at a time.
`ifndef INPUT_MAILBOX_DEFS_VH
`define INPUT_MAILBOX_DEFS_VH

// ==========================================================
// Timing
`define CLK_HZ          40000000
`define SAMPLE_MS       5
`define SAMPLE_CYCLES   (`CLK_HZ / 1000 * `SAMPLE_MS)

// ==========================================================
// Command codes
`define CMD_CLEAR_ECHO  8'h00
`define CMD_FILT_EN     8'h20
`define CMD_PAT_EN      8'h21
`define CMD_PAT_VAL     8'h22
`define CMD_RISE_EN     8'h23
`define CMD_FALL_EN     8'h24
`define CMD_CNT_EN      8'h28
`define CMD_CNT_RESET   8'h29
`define CMD_OVF_IE      8'h2A
`define CMD_MATCH_IE    8'h2B
`define CMD_EDGE_SEL    8'h2C
`define CMD_CNT_READ    8'h2F
`define CMD_INT_FLAGS   8'h60
`define CMD_EDGE_FLAGS  8'h61
`define CMD_CNT_FLAGS   8'h62

// Groups of eight per-channel codes, selected by code[7:3]
`define GRP_FILT_HIGH   5'h06
`define GRP_FILT_LOW    5'h07
`define GRP_RELOAD      5'h08
`define GRP_COMPARE     5'h09

// Top command byte value that asks for a stored setting instead
`define READBACK_MARKER 8'h01

// ==========================================================
// Status bit positions, reset values and the counter top value
`define ST_PATTERN      0
`define ST_CHANGE       1
`define ST_COUNTER      2
`define ZERO8           8'h00
`define ZERO16          16'h0000
`define MAX16           16'hFFFF

`endif

// ==== src/isolated_input_mailbox.v ====
// Mailbox command interpreter for eight isolated digital inputs.
// Assumes the host presents a command with a one-cycle cmd_valid pulse,
// and that all inputs are already synchronous to clock.
`include "input_mailbox_defs.vh"

module isolated_input_mailbox
#(
  parameter SAMPLE_CYCLES = `SAMPLE_CYCLES,
  parameter DIV_W         = 18
)
(
  input  wire        clock,
  input  wire        resetn,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_top_byte,
  input  wire [7:0]  cmd_code_byte,
  input  wire [7:0]  cmd_param_high,
  input  wire [7:0]  cmd_param_low,
  input  wire [7:0]  isolated_input,
  output reg  [7:0]  resp_input_states,
  output reg  [7:0]  resp_echo_byte,
  output reg  [7:0]  resp_high_byte,
  output reg  [7:0]  resp_low_byte,
  output reg         resp_valid,
  output reg         irq
);

  // ==========================================================
  // Storage
  reg  [DIV_W-1:0] div_reg;
  reg              tick_reg;
  reg  [7:0]       filt_en_reg;
  reg  [7:0]       pat_en_reg;
  reg  [7:0]       pat_val_reg;
  reg  [7:0]       rise_en_reg;
  reg  [7:0]       fall_en_reg;
  reg  [7:0]       cnt_en_reg;
  reg  [7:0]       ovf_ie_reg;
  reg  [7:0]       match_ie_reg;
  reg  [7:0]       edge_sel_reg;
  reg  [15:0]      high_need_reg [0:7];
  reg  [15:0]      low_need_reg  [0:7];
  reg  [15:0]      reload_reg    [0:7];
  reg  [15:0]      compare_reg   [0:7];
  reg  [15:0]      count_reg     [0:7];
  reg  [15:0]      stable_reg    [0:7];
  reg  [7:0]       state_reg;
  reg  [7:0]       rise_flag_reg;
  reg  [7:0]       fall_flag_reg;
  reg  [7:0]       ovf_flag_reg;
  reg  [7:0]       match_flag_reg;
  reg  [2:0]       int_status_reg;
  reg              pat_hit_reg;

  reg  [15:0]      count_next    [0:7];
  reg  [15:0]      stable_next   [0:7];
  reg  [7:0]       state_next;
  reg  [7:0]       rise_now;
  reg  [7:0]       fall_now;
  reg  [7:0]       ovf_now;
  reg  [7:0]       match_now;
  reg  [7:0]       cnt_clear;
  reg  [15:0]      need;
  reg              counted;
  integer          i;

  wire [7:0]  code      = cmd_code_byte;
  wire [2:0]  ch        = cmd_code_byte[2:0];
  wire [4:0]  grp       = cmd_code_byte[7:3];
  wire [15:0] param     = {cmd_param_high, cmd_param_low};
  wire        readback  = (cmd_top_byte == `READBACK_MARKER);
  wire        apply     = cmd_valid && !readback;
  wire        pat_hit   = (pat_en_reg != `ZERO8) &&
                          ((state_reg & pat_en_reg) == (pat_val_reg & pat_en_reg));

  // ==========================================================
  // Stored setting selected by a command code
  function [15:0] setting;
    input [7:0] c;
    begin
      case (c[7:3])
        `GRP_FILT_HIGH: setting = high_need_reg[c[2:0]];
        `GRP_FILT_LOW:  setting = low_need_reg[c[2:0]];
        `GRP_RELOAD:    setting = reload_reg[c[2:0]];
        `GRP_COMPARE:   setting = compare_reg[c[2:0]];
        default:
        begin
          case (c)
            `CMD_FILT_EN:  setting = {`ZERO8, filt_en_reg};
            `CMD_PAT_EN:   setting = {`ZERO8, pat_en_reg};
            `CMD_PAT_VAL:  setting = {`ZERO8, pat_val_reg};
            `CMD_RISE_EN:  setting = {`ZERO8, rise_en_reg};
            `CMD_FALL_EN:  setting = {`ZERO8, fall_en_reg};
            `CMD_CNT_EN:   setting = {`ZERO8, cnt_en_reg};
            `CMD_OVF_IE:   setting = {`ZERO8, ovf_ie_reg};
            `CMD_MATCH_IE: setting = {`ZERO8, match_ie_reg};
            `CMD_EDGE_SEL: setting = {`ZERO8, edge_sel_reg};
            default:       setting = `ZERO16;
          endcase
        end
      endcase
    end
  endfunction

  // ==========================================================
  // Sampling interval divider
  // One enable pulse per sample period; the filter counts these
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      div_reg  <= {DIV_W{1'b0}};
      tick_reg <= 1'b0;
    end
    else if (div_reg == SAMPLE_CYCLES[DIV_W-1:0] - 1'b1)
    begin
      div_reg  <= {DIV_W{1'b0}};
      tick_reg <= 1'b1;
    end
    else
    begin
      div_reg  <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Per-channel filter and up counter
  always @*
  begin
    need      = `ZERO16;
    counted   = 1'b0;
    state_next = state_reg;
    rise_now  = `ZERO8;
    fall_now  = `ZERO8;
    ovf_now   = `ZERO8;
    match_now = `ZERO8;
    cnt_clear = (apply && code == `CMD_CNT_RESET) ? cmd_param_low : `ZERO8;
    for (i = 0; i < 8; i = i + 1)
    begin
      stable_next[i] = stable_reg[i];
      count_next[i]  = count_reg[i];
      need = isolated_input[i] ? high_need_reg[i] : low_need_reg[i];
      if (!filt_en_reg[i])
      begin
        state_next[i]  = isolated_input[i];
        stable_next[i] = `ZERO16;
      end
      else if (isolated_input[i] == state_reg[i])
        stable_next[i] = `ZERO16;
      else if (tick_reg)
      begin
        // A zero count lets the new level through on the next sample
        if ({1'b0, stable_reg[i]} + 17'h00001 >= {1'b0, need})
        begin
          state_next[i]  = isolated_input[i];
          stable_next[i] = `ZERO16;
        end
        else
          stable_next[i] = stable_reg[i] + 16'h0001;
      end
      rise_now[i] = state_next[i] & ~state_reg[i];
      fall_now[i] = ~state_next[i] & state_reg[i];
      counted = edge_sel_reg[i] ? fall_now[i] : rise_now[i];
      if (cnt_clear[i])
        count_next[i] = reload_reg[i];
      else if (cnt_en_reg[i] && counted)
      begin
        if (count_reg[i] == `MAX16)
        begin
          count_next[i] = reload_reg[i];
          ovf_now[i]    = 1'b1;
        end
        else
          count_next[i] = count_reg[i] + 16'h0001;
        match_now[i] = (count_next[i] == compare_reg[i]);
      end
    end
  end

  // ==========================================================
  // Channel state, flags and interrupt status
  // Set wins over clear-on-read so no event is lost
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg      <= `ZERO8;
      rise_flag_reg  <= `ZERO8;
      fall_flag_reg  <= `ZERO8;
      ovf_flag_reg   <= `ZERO8;
      match_flag_reg <= `ZERO8;
      int_status_reg <= 3'b000;
      pat_hit_reg    <= 1'b0;
      irq            <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
        count_reg[i]  <= `ZERO16;
        stable_reg[i] <= `ZERO16;
      end
    end
    else
    begin
      state_reg   <= state_next;
      pat_hit_reg <= pat_hit;
      for (i = 0; i < 8; i = i + 1)
      begin
        count_reg[i]  <= count_next[i];
        stable_reg[i] <= stable_next[i];
      end
      if (apply && code == `CMD_EDGE_FLAGS)
      begin
        rise_flag_reg <= rise_now;
        fall_flag_reg <= fall_now;
      end
      else
      begin
        // Last change wins: a new edge replaces the opposite flag
        rise_flag_reg <= (rise_flag_reg & ~fall_now) | rise_now;
        fall_flag_reg <= (fall_flag_reg & ~rise_now) | fall_now;
      end
      if (apply && code == `CMD_CNT_FLAGS)
      begin
        ovf_flag_reg   <= ovf_now;
        match_flag_reg <= match_now;
      end
      else
      begin
        ovf_flag_reg   <= ovf_flag_reg | ovf_now;
        match_flag_reg <= match_flag_reg | match_now;
      end
      if (apply && code == `CMD_INT_FLAGS)
        int_status_reg <= 3'b000;
      if (pat_hit && !pat_hit_reg)
        int_status_reg[`ST_PATTERN] <= 1'b1;
      if (|((rise_now & rise_en_reg) | (fall_now & fall_en_reg)))
        int_status_reg[`ST_CHANGE] <= 1'b1;
      if (|((ovf_now & ovf_ie_reg) | (match_now & match_ie_reg)))
        int_status_reg[`ST_COUNTER] <= 1'b1;
      // Interrupt line follows any pending event class
      irq <= (pat_hit && !pat_hit_reg) ||
             (|((rise_now & rise_en_reg) | (fall_now & fall_en_reg))) ||
             (|((ovf_now & ovf_ie_reg) | (match_now & match_ie_reg))) ||
             ((|int_status_reg) && !(apply && code == `CMD_INT_FLAGS));
    end
  end

  // ==========================================================
  // Configuration commands
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      filt_en_reg  <= `ZERO8;
      pat_en_reg   <= `ZERO8;
      pat_val_reg  <= `ZERO8;
      rise_en_reg  <= `ZERO8;
      fall_en_reg  <= `ZERO8;
      cnt_en_reg   <= `ZERO8;
      ovf_ie_reg   <= `ZERO8;
      match_ie_reg <= `ZERO8;
      edge_sel_reg <= `ZERO8;
      for (i = 0; i < 8; i = i + 1)
      begin
        high_need_reg[i] <= `ZERO16;
        low_need_reg[i]  <= `ZERO16;
        reload_reg[i]    <= `ZERO16;
        compare_reg[i]   <= `ZERO16;
      end
    end
    else if (apply)
    begin
      case (code)
        `CMD_FILT_EN:  filt_en_reg  <= cmd_param_low;
        `CMD_PAT_EN:   pat_en_reg   <= cmd_param_low;
        `CMD_PAT_VAL:  pat_val_reg  <= cmd_param_low;
        `CMD_RISE_EN:  rise_en_reg  <= cmd_param_low;
        `CMD_FALL_EN:  fall_en_reg  <= cmd_param_low;
        `CMD_CNT_EN:   cnt_en_reg   <= cmd_param_low;
        `CMD_OVF_IE:   ovf_ie_reg   <= cmd_param_low;
        `CMD_MATCH_IE: match_ie_reg <= cmd_param_low;
        `CMD_EDGE_SEL: edge_sel_reg <= cmd_param_low;
        default:
        begin
          case (grp)
            `GRP_FILT_HIGH: high_need_reg[ch] <= param;
            `GRP_FILT_LOW:  low_need_reg[ch]  <= param;
            `GRP_RELOAD:
            begin
              if (cnt_en_reg[ch])
                reload_reg[ch] <= param;
            end
            `GRP_COMPARE:
            begin
              if (cnt_en_reg[ch])
                compare_reg[ch] <= param;
            end
            default:
              reload_reg[ch] <= reload_reg[ch];
          endcase
        end
      endcase
    end
  end

  // ==========================================================
  // Response mailbox
  // Echo lands with the data in the same cycle, so a host that waits
  // for the echo always sees complete results
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      resp_input_states <= `ZERO8;
      resp_echo_byte    <= `ZERO8;
      resp_high_byte    <= `ZERO8;
      resp_low_byte     <= `ZERO8;
      resp_valid        <= 1'b0;
    end
    else
    begin
      resp_valid <= cmd_valid;
      if (cmd_valid)
      begin
        resp_input_states <= state_reg;
        resp_echo_byte    <= code;
        resp_high_byte    <= `ZERO8;
        resp_low_byte     <= `ZERO8;
        if (readback)
        begin
          {resp_high_byte, resp_low_byte} <= setting(code);
        end
        else
        begin
          case (code)
            `CMD_CLEAR_ECHO:
              resp_echo_byte <= `ZERO8;
            `CMD_CNT_READ:
            begin
              resp_high_byte <= count_reg[cmd_param_low[2:0]][15:8];
              resp_low_byte  <= count_reg[cmd_param_low[2:0]][7:0];
            end
            `CMD_INT_FLAGS:
              resp_low_byte <= {5'b00000, int_status_reg};
            `CMD_EDGE_FLAGS:
            begin
              resp_high_byte <= fall_flag_reg;
              resp_low_byte  <= rise_flag_reg;
            end
            `CMD_CNT_FLAGS:
            begin
              resp_high_byte <= ovf_flag_reg;
              resp_low_byte  <= match_flag_reg;
            end
            default:
              resp_low_byte <= `ZERO8;
          endcase
        end
      end
    end
  end

endmodule

// ==== testbench/input_mailbox_monitor.sv ====
// Port assertions for the isolated input mailbox interpreter.
// Assumes one clock domain and an active-low asynchronous reset.
module input_mailbox_monitor
#(
  parameter SAMPLE_CYCLES = 10
)
(
  input wire       clock,
  input wire       resetn,
  input wire       cmd_valid,
  input wire [7:0] cmd_top_byte,
  input wire [7:0] cmd_code_byte,
  input wire [7:0] resp_echo_byte,
  input wire [7:0] resp_high_byte,
  input wire [7:0] resp_low_byte,
  input wire       resp_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Command and response relations
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_answer_next: assert property (cmd_valid |=> resp_valid)
    else $error("no answer one cycle after a command");
  a_answer_once: assert property (!cmd_valid |=> !resp_valid)
    else $error("answer without a command");
  a_echo_code: assert property (cmd_valid && cmd_code_byte != 8'h00
    |=> resp_echo_byte == $past(cmd_code_byte))
    else $error("echo differs from command code");
  a_echo_clear: assert property (cmd_valid && cmd_code_byte == 8'h00
    |=> resp_echo_byte == 8'h00)
    else $error("echo not cleared");
  a_resp_hold: assert property (!cmd_valid
    |=> $stable({resp_echo_byte, resp_high_byte, resp_low_byte}))
    else $error("response changed without a command");
  a_status_bits: assert property (cmd_valid && cmd_top_byte == 8'h00
    && cmd_code_byte == 8'h60 |=> resp_low_byte[7:3] == 5'h00)
    else $error("undefined status bits set");
  a_edge_excl: assert property (cmd_valid && cmd_top_byte == 8'h00
    && cmd_code_byte == 8'h61 |=> (resp_high_byte & resp_low_byte) == 8'h00)
    else $error("channel flagged both ways");
  a_unknown_quiet: assert property (cmd_valid && cmd_code_byte == 8'h07
    |=> {resp_high_byte, resp_low_byte} == 16'h0000)
    else $error("data returned for an unhandled code");
endmodule

bind isolated_input_mailbox input_mailbox_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_mon (
  .clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_top_byte(cmd_top_byte),
  .cmd_code_byte(cmd_code_byte), .resp_echo_byte(resp_echo_byte),
  .resp_high_byte(resp_high_byte), .resp_low_byte(resp_low_byte), .resp_valid(resp_valid));

// ==== testbench/host_mailbox_model.sv ====
// Host software model: writes one mailbox command at a time.
// Assumes the bench calls issue and the device answers with resp_valid.
module host_mailbox_model
(
  input  wire        clock,
  input  wire        resp_valid,
  output logic       cmd_valid,
  output logic [7:0] cmd_top_byte,
  output logic [7:0] cmd_code_byte,
  output logic [7:0] cmd_param_high,
  output logic [7:0] cmd_param_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Command issue
  initial
  begin
    cmd_valid = 1'b0;
    {cmd_top_byte, cmd_code_byte, cmd_param_high, cmd_param_low} = 32'h00000000;
  end

  task automatic issue(input logic [7:0] top, code, hi, lo);
    int n;
    @(posedge clock);
    cmd_valid <= 1'b1;
    {cmd_top_byte, cmd_code_byte, cmd_param_high, cmd_param_low} <= {top, code, hi, lo};
    @(posedge clock);
    cmd_valid <= 1'b0;
    // Stale bytes are scrambled so nothing relies on them after the take
    {cmd_top_byte, cmd_code_byte, cmd_param_high, cmd_param_low} <= ~{top, code, hi, lo};
    // Next command only after the echo, since the mailbox holds one answer
    for (n = 0; n < 20; n++)
    begin
      @(negedge clock);
      if (resp_valid === 1'b1)
        break;
    end
  endtask
endmodule

// ==== testbench/isolated_input_mailbox_tb.sv ====
// Self-checking bench for the isolated input mailbox interpreter.
// Assumes a short sample period so that filter windows stay brief.
`define CHK(g, e) \
  begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module isolated_input_mailbox_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Harness
  logic clock, resetn, cmd_valid, resp_valid, irq;
  logic [7:0] cmd_top_byte, cmd_code_byte, cmd_param_high, cmd_param_low, isolated_input;
  logic [7:0] resp_input_states, resp_echo_byte, resp_high_byte, resp_low_byte;
  logic [7:0] states_exp, c;
  logic [63:0] expq[$];
  logic [63:0] e;
  logic [15:0] w;
  logic [23:0] cfg[14] = '{24'h200080, 24'h210000, 24'h230000, 24'h240000, 24'h2C0000,
    24'h370003, 24'h3F0003, 24'h40FFFE, 24'h48FFFF, 24'h2B0001, 24'h290001,
    24'h600000, 24'h610000, 24'h620000};
  int errors, n_tests, i;

  isolated_input_mailbox #(.SAMPLE_CYCLES(10)) u_isolated_input_mailbox (
    .clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_top_byte(cmd_top_byte),
    .cmd_code_byte(cmd_code_byte), .cmd_param_high(cmd_param_high),
    .cmd_param_low(cmd_param_low), .isolated_input(isolated_input),
    .resp_input_states(resp_input_states), .resp_echo_byte(resp_echo_byte),
    .resp_high_byte(resp_high_byte), .resp_low_byte(resp_low_byte),
    .resp_valid(resp_valid), .irq(irq));
  host_mailbox_model u_host_mailbox_model (
    .clock(clock), .resp_valid(resp_valid), .cmd_valid(cmd_valid),
    .cmd_top_byte(cmd_top_byte), .cmd_code_byte(cmd_code_byte),
    .cmd_param_high(cmd_param_high), .cmd_param_low(cmd_param_low));

  task automatic run(input logic [7:0] top, code, hi, lo, input logic [15:0] ex, m);
    expq.push_back({16'hFFFF, m, states_exp, code, ex & m});
    u_host_mailbox_model.issue(top, code, hi, lo);
  endtask

  task automatic drive(input logic [7:0] v, input int n);
    @(posedge clock);
    isolated_input <= v;
    repeat (n) @(posedge clock);
  endtask

  task automatic tally_and_finish();
    errors += expq.size();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Oldest note is matched against each answer
  always @(posedge clock)
    if (resp_valid === 1'b1)
    begin
      e = expq.pop_front();
      `CHK({resp_input_states, resp_echo_byte, resp_high_byte, resp_low_byte} & e[63:32],
        e[31:0])
    end

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial
  begin
    #(4000 * 25);
    errors++;
    tally_and_finish();
  end

  // ==========================================
  // Scenarios
  initial
  begin
    resetn = 1'b0;
    isolated_input = 8'h00;
    states_exp = 8'h00;
    void'($urandom(98));
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    run(8'h00, 8'h28, 8'h00, 8'h0F, 16'h0000, 16'h0000);
    for (c = 8'h20; c <= 8'h24; c++)
    begin
      w = $urandom;
      run(8'h00, c, 8'h00, w[7:0], 16'h0000, 16'h0000);
      run(8'h01, c, 8'h00, 8'h00, w, 16'h00FF);
    end
    for (c = 8'h30; c <= 8'h4F; c++)
    begin
      w = $urandom;
      run(8'h00, c, w[15:8], w[7:0], 16'h0000, 16'h0000);
      run(8'h01, c, 8'h00, 8'h00, (c < 8'h40 || !c[2]) ? w : 16'h0000, 16'hFFFF);
    end
    for (i = 0; i < 14; i++)
      run(8'h00, cfg[i][23:16], cfg[i][15:8], cfg[i][7:0], 16'h0000, 16'h0000);
    run(8'h00, 8'h07, 8'h00, 8'h00, 16'h0000, 16'hFFFF);
    drive(8'h5A, 3);
    states_exp = 8'h5A;
    run(8'h00, 8'h61, 8'h00, 8'h00, 16'h005A, 16'hFFFF);
    drive(8'h18, 3);
    states_exp = 8'h18;
    run(8'h00, 8'h61, 8'h00, 8'h00, 16'h4200, 16'hFFFF);
    drive(8'h19, 3);
    states_exp = 8'h19;
    `CHK(irq, 1'b1)
    run(8'h00, 8'h2F, 8'h00, 8'h00, 16'hFFFF, 16'hFFFF);
    run(8'h00, 8'h60, 8'h00, 8'h00, 16'h0004, 16'h00FF);
    run(8'h00, 8'h62, 8'h00, 8'h00, 16'h0001, 16'hFFFF);
    drive(8'h18, 3);
    drive(8'h19, 3);
    run(8'h00, 8'h62, 8'h00, 8'h00, 16'h0100, 16'hFFFF);
    run(8'h00, 8'h2F, 8'h00, 8'h00, 16'hFFFE, 16'hFFFF);
    run(8'h00, 8'h2C, 8'h00, 8'h01, 16'h0000, 16'h0000);
    drive(8'h18, 3);
    states_exp = 8'h18;
    run(8'h00, 8'h2F, 8'h00, 8'h00, 16'hFFFF, 16'hFFFF);
    drive(8'h98, 5);
    drive(8'h18, 40);
    run(8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
    drive(8'h98, 60);
    states_exp = 8'h98;
    run(8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
    drive(8'h18, 5);
    drive(8'h98, 40);
    run(8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000);
    // Pattern, change and pending counter classes all show in one status read
    run(8'h00, 8'h22, 8'h00, 8'h9A, 16'h0000, 16'h0000);
    run(8'h00, 8'h23, 8'h00, 8'h02, 16'h0000, 16'h0000);
    run(8'h00, 8'h21, 8'h00, 8'hFF, 16'h0000, 16'h0000);
    drive(8'h9A, 3);
    states_exp = 8'h9A;
    `CHK(irq, 1'b1)
    run(8'h00, 8'h60, 8'h00, 8'h00, 16'h0007, 16'h00FF);
    `CHK(irq, 1'b0)
    repeat (4) @(posedge clock);
    tally_and_finish();
  end
endmodule
